// ### include/art_defs.svh
// Purpose: constants for the auto-reload timer (offsets, fields, reset values, divisors)
// Assumes: 8-bit special function register port, one 100 MHz clock
// Notes:   definitions only
// How it works
// - with split mode clear the timer counts as one 16-bit up counter, reloads on 0xFFFF->0 and sets the high flag.
// - in 16-bit mode an enabled timer interrupt is requested on every full 16-bit overflow.
// - in 16-bit mode with the low-byte enable set, a low-byte 0xFF->0 rollover also requests an interrupt.
// - with split mode set the two bytes are separate 8-bit timers, each reloading from its own reload byte.
// - run control gates the whole 16-bit timer, but in split mode only the high byte; the low byte always runs.
// - per byte (16-bit mode uses the low-byte select), clock select 1 picks system clock, 0 picks system/12 or external/8 by the external select bit.
// - the external oscillator is synchronised to the system clock before its divided ticks advance the counter.
// - in split mode each byte sets its own overflow flag when it rolls over from 0xFF to its reload byte.
// - in split mode high-byte overflows request an interrupt, and low-byte ones too when the low enable is set.
// - the overflow flags are only ever cleared by a software write to the control register.
// - a capture mode, chosen by the capture enable bit, measures the slow oscillator on its rising edges.
`ifndef ART_DEFS_SVH
`define ART_DEFS_SVH

`define ART_ADDR_CTRL   8'h91
`define ART_ADDR_RLL    8'h92
`define ART_ADDR_RLH    8'h93
`define ART_ADDR_CNTL   8'h94
`define ART_ADDR_CNTH   8'h95

`define ART_BIT_HF      7
`define ART_BIT_LF      6
`define ART_BIT_LFEN    5
`define ART_BIT_CAPEN   4
`define ART_BIT_SPLIT   3
`define ART_BIT_RUN     2
`define ART_BIT_XCLK    0

`define ART_BYTE_RST    8'h00
`define ART_BYTE_MAX    8'hFF
`define ART_WORD_MAX    16'hFFFF
`define ART_RD_UNMAPPED 8'h00

`define ART_SYS_DIV     4'hC
`define ART_EXT_DIV_LAST 3'h7

`endif

// ### include/art_pkg.sv
// Purpose: shared types of the auto-reload timer
// Assumes: nothing
// Notes:   constants live in art_defs.svh
package art_pkg;
  typedef enum logic {
    ART_MODE_16,
    ART_MODE_SPLIT
  } art_mode_t;
endpackage

// ### include/art_tick_if.sv
// Purpose: carries the prescaler ticks into the timer core
// Assumes: all signals are one-cycle pulses on clk_in
// Notes:   none
`timescale 1ns/1ps
interface art_tick_if;
  logic sys_div12_tick;
  logic ext_div8_tick;
  logic lfo_rise;
  modport src (output sys_div12_tick, output ext_div8_tick, output lfo_rise);
  modport snk (input sys_div12_tick, input ext_div8_tick, input lfo_rise);
endinterface

// ### core/art_prescale.sv
// Purpose: system/12 and external/8 tick enables, slow oscillator edge detect
// Assumes: ext_osc_in and lfo_in are asynchronous, slower than half of clk_in
// Notes:   two-flop synchronisers, edges taken off the second stage only
`timescale 1ns/1ps
`include "art_defs.svh"
module art_prescale
  import art_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic ext_osc_in,
  input  wire logic lfo_in,
  art_tick_if.src   ticks_out
);
  logic       ext_s1_q, ext_s2_q, ext_s3_q;
  logic       lfo_s1_q, lfo_s2_q, lfo_s3_q;
  logic [3:0] div12_q, div12_d;
  logic [2:0] ext8_q, ext8_d;
  logic       ext_rise;

  always_comb
  begin
    ext_rise = ext_s2_q && !ext_s3_q;
    div12_d  = (div12_q == `ART_SYS_DIV - 4'h1) ? 4'h0 : div12_q + 4'h1;
    ext8_d   = ext_rise ? ext8_q + 3'h1 : ext8_q;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      lfo_s1_q <= 1'b0;
      lfo_s2_q <= 1'b0;
      lfo_s3_q <= 1'b0;
      div12_q  <= 4'h0;
      ext8_q   <= 3'h0;
    end
    else
    begin
      ext_s1_q <= ext_osc_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      lfo_s1_q <= lfo_in;
      lfo_s2_q <= lfo_s1_q;
      lfo_s3_q <= lfo_s2_q;
      div12_q  <= div12_d;
      ext8_q   <= ext8_d;
    end
  end

  assign ticks_out.sys_div12_tick = (div12_q == `ART_SYS_DIV - 4'h1);
  assign ticks_out.ext_div8_tick  = ext_rise && (ext8_q == `ART_EXT_DIV_LAST);
  assign ticks_out.lfo_rise       = lfo_s2_q && !lfo_s3_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_div12_spacing: assert property (
    ticks_out.sys_div12_tick |-> ##1 (!ticks_out.sys_div12_tick)[*8] ##1
      !ticks_out.sys_div12_tick ##1 !ticks_out.sys_div12_tick ##1
      !ticks_out.sys_div12_tick ##1 ticks_out.sys_div12_tick)
    else $error("system/12 tick spacing is not twelve cycles");
  a_ext_sync_path: assert property (
    ticks_out.ext_div8_tick |-> $past(ext_s1_q) && !$past(ext_s2_q))
    else $error("external tick not taken from synchronised edge");
endmodule

// ### core/art_timer.sv
// Purpose: 16-bit auto-reload timer, splittable into two 8-bit timers, with capture
// Assumes: register port is synchronous to clk_in; clock select bits come from outside
// Notes:   read data is registered, one cycle after the read strobe
`timescale 1ns/1ps
`include "art_defs.svh"
module art_timer
  import art_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  input  wire logic       high_byte_clock_select_in,
  input  wire logic       low_byte_clock_select_in,
  input  wire logic       timer_irq_enable_in,
  input  wire logic       ext_osc_in,
  input  wire logic       lfo_in,
  output logic            irq_out,
  output logic            high_overflow_flag_out,
  output logic            low_overflow_flag_out
);
  art_tick_if u_ticks ();

  art_prescale u_prescale (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .ext_osc_in (ext_osc_in),
    .lfo_in     (lfo_in),
    .ticks_out  (u_ticks.src)
  );

  // control register fields
  logic       high_overflow_flag_q, high_overflow_flag_d;
  logic       low_overflow_flag_q,  low_overflow_flag_d;
  logic       low_byte_irq_enable_q, low_byte_irq_enable_d;
  logic       capture_enable_q,     capture_enable_d;
  logic       split_mode_select_q,  split_mode_select_d;
  logic       run_control_q,        run_control_d;
  logic       ext_clock_select_q,   ext_clock_select_d;
  // data bytes
  logic [7:0] reload_low_byte_q,    reload_low_byte_d;
  logic [7:0] reload_high_byte_q,   reload_high_byte_d;
  logic [7:0] counter_low_byte_q,   counter_low_byte_d;
  logic [7:0] counter_high_byte_q,  counter_high_byte_d;
  logic [7:0] rdata_q,              rdata_d;

  art_mode_t  mode;
  logic       tick_lo;
  logic       tick_hi;
  logic       lo_ovf;
  logic       hi_ovf;
  logic       cap_evt;
  logic       wr_ctl;
  logic       wr_rll;
  logic       wr_rlh;
  logic       wr_cntl;
  logic       wr_cnth;
  logic [7:0] ctl_view;

  function automatic logic sel_tick(
    input logic sys_sel,
    input logic xclk,
    input logic div12,
    input logic ext8
  );
    return sys_sel ? 1'b1 : (xclk ? ext8 : div12);
  endfunction

  function automatic logic [7:0] byte_next(
    input logic [7:0] cur,
    input logic [7:0] rl
  );
    return (cur == `ART_BYTE_MAX) ? rl : cur + 8'h01;
  endfunction

  // decode and clock choice
  always_comb
  begin
    mode    = split_mode_select_q ? ART_MODE_SPLIT : ART_MODE_16;
    wr_ctl  = sfr_wr_in && (sfr_addr_in == `ART_ADDR_CTRL);
    wr_rll  = sfr_wr_in && (sfr_addr_in == `ART_ADDR_RLL);
    wr_rlh  = sfr_wr_in && (sfr_addr_in == `ART_ADDR_RLH);
    wr_cntl = sfr_wr_in && (sfr_addr_in == `ART_ADDR_CNTL);
    wr_cnth = sfr_wr_in && (sfr_addr_in == `ART_ADDR_CNTH);
    tick_lo = sel_tick(low_byte_clock_select_in, ext_clock_select_q,
                       u_ticks.sys_div12_tick, u_ticks.ext_div8_tick);
    tick_hi = sel_tick(high_byte_clock_select_in, ext_clock_select_q,
                       u_ticks.sys_div12_tick, u_ticks.ext_div8_tick);
    cap_evt = capture_enable_q && u_ticks.lfo_rise;
  end

  // counter next state; a software write to a counter byte beats the count
  always_comb
  begin
    counter_low_byte_d  = counter_low_byte_q;
    counter_high_byte_d = counter_high_byte_q;
    lo_ovf              = 1'b0;
    hi_ovf              = 1'b0;
    case (mode)
      ART_MODE_16:
      begin
        // 16-bit mode runs off the low-byte clock choice
        if (run_control_q && tick_lo)
        begin
          lo_ovf = (counter_low_byte_q == `ART_BYTE_MAX);
          if ({counter_high_byte_q, counter_low_byte_q} == `ART_WORD_MAX)
          begin
            hi_ovf = 1'b1;
            {counter_high_byte_d, counter_low_byte_d} =
              {reload_high_byte_q, reload_low_byte_q};
          end
          else
          begin
            {counter_high_byte_d, counter_low_byte_d} =
              {counter_high_byte_q, counter_low_byte_q} + 16'h0001;
          end
        end
      end
      ART_MODE_SPLIT:
      begin
        if (tick_lo)
        begin
          lo_ovf             = (counter_low_byte_q == `ART_BYTE_MAX);
          counter_low_byte_d = byte_next(counter_low_byte_q, reload_low_byte_q);
        end
        if (run_control_q && tick_hi)
        begin
          hi_ovf              = (counter_high_byte_q == `ART_BYTE_MAX);
          counter_high_byte_d = byte_next(counter_high_byte_q, reload_high_byte_q);
        end
      end
      default:
      begin
        lo_ovf = 1'b0;
      end
    endcase
    if (wr_cntl)
      counter_low_byte_d = sfr_wdata_in;
    if (wr_cnth)
      counter_high_byte_d = sfr_wdata_in;
  end

  // reload bytes; a capture in the same cycle as a write wins
  always_comb
  begin
    reload_low_byte_d  = wr_rll ? sfr_wdata_in : reload_low_byte_q;
    reload_high_byte_d = wr_rlh ? sfr_wdata_in : reload_high_byte_q;
    if (cap_evt)
    begin
      reload_low_byte_d  = counter_low_byte_q;
      reload_high_byte_d = counter_high_byte_q;
    end
  end

  // control fields; hardware set beats a software clear in the same cycle
  always_comb
  begin
    high_overflow_flag_d  = hi_ovf || cap_evt ||
      (wr_ctl ? sfr_wdata_in[`ART_BIT_HF] : high_overflow_flag_q);
    low_overflow_flag_d   = lo_ovf ||
      (wr_ctl ? sfr_wdata_in[`ART_BIT_LF] : low_overflow_flag_q);
    low_byte_irq_enable_d = wr_ctl ? sfr_wdata_in[`ART_BIT_LFEN] : low_byte_irq_enable_q;
    capture_enable_d      = wr_ctl ? sfr_wdata_in[`ART_BIT_CAPEN] : capture_enable_q;
    split_mode_select_d   = wr_ctl ? sfr_wdata_in[`ART_BIT_SPLIT] : split_mode_select_q;
    run_control_d         = wr_ctl ? sfr_wdata_in[`ART_BIT_RUN] : run_control_q;
    ext_clock_select_d    = wr_ctl ? sfr_wdata_in[`ART_BIT_XCLK] : ext_clock_select_q;
  end

  // read path; bit 1 of control is not implemented and reads zero
  always_comb
  begin
    ctl_view                  = `ART_BYTE_RST;
    ctl_view[`ART_BIT_HF]     = high_overflow_flag_q;
    ctl_view[`ART_BIT_LF]     = low_overflow_flag_q;
    ctl_view[`ART_BIT_LFEN]   = low_byte_irq_enable_q;
    ctl_view[`ART_BIT_CAPEN]  = capture_enable_q;
    ctl_view[`ART_BIT_SPLIT]  = split_mode_select_q;
    ctl_view[`ART_BIT_RUN]    = run_control_q;
    ctl_view[`ART_BIT_XCLK]   = ext_clock_select_q;
    rdata_d                   = rdata_q;
    if (sfr_rd_in)
    begin
      case (sfr_addr_in)
        `ART_ADDR_CTRL: rdata_d = ctl_view;
        `ART_ADDR_RLL:  rdata_d = reload_low_byte_q;
        `ART_ADDR_RLH:  rdata_d = reload_high_byte_q;
        `ART_ADDR_CNTL: rdata_d = counter_low_byte_q;
        `ART_ADDR_CNTH: rdata_d = counter_high_byte_q;
        default:        rdata_d = `ART_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      high_overflow_flag_q  <= 1'b0;
      low_overflow_flag_q   <= 1'b0;
      low_byte_irq_enable_q <= 1'b0;
      capture_enable_q      <= 1'b0;
      split_mode_select_q   <= 1'b0;
      run_control_q         <= 1'b0;
      ext_clock_select_q    <= 1'b0;
      reload_low_byte_q     <= `ART_BYTE_RST;
      reload_high_byte_q    <= `ART_BYTE_RST;
      counter_low_byte_q    <= `ART_BYTE_RST;
      counter_high_byte_q   <= `ART_BYTE_RST;
      rdata_q               <= `ART_BYTE_RST;
    end
    else
    begin
      high_overflow_flag_q  <= high_overflow_flag_d;
      low_overflow_flag_q   <= low_overflow_flag_d;
      low_byte_irq_enable_q <= low_byte_irq_enable_d;
      capture_enable_q      <= capture_enable_d;
      split_mode_select_q   <= split_mode_select_d;
      run_control_q         <= run_control_d;
      ext_clock_select_q    <= ext_clock_select_d;
      reload_low_byte_q     <= reload_low_byte_d;
      reload_high_byte_q    <= reload_high_byte_d;
      counter_low_byte_q    <= counter_low_byte_d;
      counter_high_byte_q   <= counter_high_byte_d;
      rdata_q               <= rdata_d;
    end
  end

  // request stays up while a serviced flag is still set, so software must clear it
  assign irq_out = timer_irq_enable_in && (high_overflow_flag_q ||
                   (low_byte_irq_enable_q && low_overflow_flag_q));
  assign high_overflow_flag_out = high_overflow_flag_q;
  assign low_overflow_flag_out  = low_overflow_flag_q;
  assign sfr_rdata_out          = rdata_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // the low flag sets on any low-byte rollover, so the low checks hold in both modes
  a_wrap_reload16: assert property (
    (mode == ART_MODE_16) && run_control_q && tick_lo && !wr_cntl && !wr_cnth &&
    ({counter_high_byte_q, counter_low_byte_q} == `ART_WORD_MAX)
    |=> high_overflow_flag_q &&
        ({counter_high_byte_q, counter_low_byte_q} ==
         {$past(reload_high_byte_q), $past(reload_low_byte_q)}))
    else $error("16-bit wrap did not reload or set the high flag");
  a_irq_full16: assert property (
    (mode == ART_MODE_16) && run_control_q && tick_lo &&
    ({counter_high_byte_q, counter_low_byte_q} == `ART_WORD_MAX)
    ##1 timer_irq_enable_in |-> irq_out)
    else $error("no request after a full 16-bit overflow");
  a_irq_lowbyte: assert property (
    lo_ovf && low_byte_irq_enable_q && !wr_ctl ##1 timer_irq_enable_in |-> irq_out)
    else $error("no request after a low byte overflow");
  a_count16_step: assert property (
    (mode == ART_MODE_16) && run_control_q && tick_lo && !wr_cntl && !wr_cnth &&
    ({counter_high_byte_q, counter_low_byte_q} != `ART_WORD_MAX)
    |=> {counter_high_byte_q, counter_low_byte_q} ==
        {$past(counter_high_byte_q), $past(counter_low_byte_q)} + 16'h0001)
    else $error("16-bit counter did not step by one");
  a_lo16_flag: assert property (
    (mode == ART_MODE_16) && run_control_q && tick_lo &&
    (counter_low_byte_q == `ART_BYTE_MAX) |=> low_overflow_flag_q)
    else $error("low flag not set on 16-bit low byte rollover");
  a_split_lo_wrap: assert property (
    (mode == ART_MODE_SPLIT) && tick_lo && !wr_cntl &&
    (counter_low_byte_q == `ART_BYTE_MAX)
    |=> low_overflow_flag_q && (counter_low_byte_q == $past(reload_low_byte_q)))
    else $error("split low byte wrap wrong");
  a_split_lo_runs: assert property (
    (mode == ART_MODE_SPLIT) && !run_control_q && tick_lo && !wr_cntl &&
    (counter_low_byte_q != `ART_BYTE_MAX)
    |=> counter_low_byte_q == $past(counter_low_byte_q) + 8'h01)
    else $error("low byte stalled in split mode");
  a_split_hi_held: assert property (
    (mode == ART_MODE_SPLIT) && !run_control_q && !wr_cnth |=> $stable(counter_high_byte_q))
    else $error("high byte moved while stopped");
  a_stop16_held: assert property (
    (mode == ART_MODE_16) && !run_control_q && !wr_cntl && !wr_cnth
    |=> $stable(counter_low_byte_q) && $stable(counter_high_byte_q))
    else $error("16-bit counter moved while stopped");
  a_split_hi_wrap: assert property (
    (mode == ART_MODE_SPLIT) && run_control_q && tick_hi && !wr_cnth &&
    (counter_high_byte_q == `ART_BYTE_MAX)
    |=> high_overflow_flag_q && (counter_high_byte_q == $past(reload_high_byte_q)))
    else $error("split high byte wrap wrong");
  a_flag_sticky: assert property (
    high_overflow_flag_q && !(wr_ctl && !sfr_wdata_in[`ART_BIT_HF]) |=> high_overflow_flag_q)
    else $error("high flag cleared without a software write");
  a_lo_flag_sticky: assert property (
    low_overflow_flag_q && !(wr_ctl && !sfr_wdata_in[`ART_BIT_LF]) |=> low_overflow_flag_q)
    else $error("low flag cleared without a software write");
  a_wr_reload: assert property (
    wr_rll && !cap_evt |=> reload_low_byte_q == $past(sfr_wdata_in))
    else $error("reload low byte write lost");
  a_cap_idle: assert property (
    !capture_enable_q && !wr_rll && !wr_rlh
    |=> $stable(reload_low_byte_q) && $stable(reload_high_byte_q))
    else $error("reload bytes changed with capture off");
  a_irq_split_hi: assert property (
    (mode == ART_MODE_SPLIT) && run_control_q && tick_hi &&
    (counter_high_byte_q == `ART_BYTE_MAX) ##1 timer_irq_enable_in |-> irq_out)
    else $error("no request after split high overflow");
  a_capture_copy: assert property (
    cap_evt |=> high_overflow_flag_q &&
      ({reload_high_byte_q, reload_low_byte_q} ==
       {$past(counter_high_byte_q), $past(counter_low_byte_q)}))
    else $error("capture did not copy the count");

  c_wrap16:   cover property ((mode == ART_MODE_16) && hi_ovf);
  c_split_lo: cover property ((mode == ART_MODE_SPLIT) && lo_ovf && !run_control_q);
  c_capture:  cover property (cap_evt ##1 irq_out);
  c_set_clr:  cover property (hi_ovf && wr_ctl && !sfr_wdata_in[`ART_BIT_HF]);
  c_lo_irq:   cover property ((mode == ART_MODE_SPLIT) && lo_ovf && low_byte_irq_enable_q);
endmodule

// ### tb/art_timer_bench.sv
// Purpose: self-checking bench for the auto-reload timer, register reads checked from a queue
// Assumes: inputs change 1 ns after the rising edge; read data valid the cycle after the strobe
// Notes:   counts under a divided clock are checked with a mask, the start phase is not known
`timescale 1ns/1ps
`include "art_defs.svh"
module art_timer_bench
  import art_pkg::*;
;
  logic       clk_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00;
  logic       sfr_wr_in = 1'b0;
  logic       sfr_rd_in = 1'b0;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic [7:0] sfr_rdata_out;
  logic       hsel = 1'b1;
  logic       lsel = 1'b1;
  logic       irq_en = 1'b1;
  logic       ext_osc_in = 1'b0;
  logic       lfo_in = 1'b0;
  logic       irq_out;
  logic       hflag;
  logic       lflag;
  logic       rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic [7:0] v;
  int         err_count = 0;
  int         compares = 0;

  art_timer i_dut (
    .clk_in                    (clk_in),
    .rst_b_in                  (rst_b_in),
    .sfr_addr_in               (sfr_addr_in),
    .sfr_wr_in                 (sfr_wr_in),
    .sfr_rd_in                 (sfr_rd_in),
    .sfr_wdata_in              (sfr_wdata_in),
    .sfr_rdata_out             (sfr_rdata_out),
    .high_byte_clock_select_in (hsel),
    .low_byte_clock_select_in  (lsel),
    .timer_irq_enable_in       (irq_en),
    .ext_osc_in                (ext_osc_in),
    .lfo_in                    (lfo_in),
    .irq_out                   (irq_out),
    .high_overflow_flag_out    (hflag),
    .low_overflow_flag_out     (lflag)
  );

  always #5 clk_in = ~clk_in;
  // free-running oscillator, eight system cycles a period
  always #40 ext_osc_in = ~ext_osc_in;

  task automatic stop_test();
    $display("errors %0d, compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %b", $time, what, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(posedge clk_in);
    #1;
    sfr_wr_in = 1'b0;
  endtask

  // two writes to one address on consecutive edges, strobe held up between them
  task automatic wr2(input logic [7:0] a, input logic [7:0] d1, input logic [7:0] d2);
    @(posedge clk_in);
    #1;
    sfr_addr_in = a;
    sfr_wdata_in = d1;
    sfr_wr_in = 1'b1;
    @(posedge clk_in);
    #1;
    sfr_wdata_in = d2;
    @(posedge clk_in);
    #1;
    sfr_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_in);
    #1;
    exp_q.push_back({e, m});
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(posedge clk_in);
    #1;
    sfr_rd_in = 1'b0;
  endtask

  task automatic wait_flag(input bit high);
    int n;
    n = 0;
    while ((high ? hflag : lflag) !== 1'b1 && n < 60)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk(high ? hflag : lflag, 1'b1, "overflow flag never set");
  endtask

  task automatic lfo_pulse();
    lfo_in = 1'b1;
    repeat (6) @(posedge clk_in);
    #1;
    lfo_in = 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
  endtask

  always @(posedge clk_in) rd_seen <= sfr_rd_in;

  // takes the oldest note whenever a read answer stands on the bus
  always @(negedge clk_in)
  begin
    if (rd_seen)
    begin
      note = exp_q.pop_front();
      compares++;
      if ((sfr_rdata_out & note[7:0]) !== note[15:8])
      begin
        err_count++;
        $display("[FAIL] %0t read data %h", $time, sfr_rdata_out);
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    void'($urandom(42));
    repeat (4) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    for (int a = 8'h91; a <= 8'h96; a++) rd(8'(a), 8'h00, 8'hFF);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      wr(`ART_ADDR_RLL, v);
      rd(`ART_ADDR_RLL, v, 8'hFF);
      wr(`ART_ADDR_RLH, ~v);
      rd(`ART_ADDR_RLH, ~v, 8'hFF);
    end
    wr(`ART_ADDR_CTRL, 8'h3B);
    rd(`ART_ADDR_CTRL, 8'h39, 8'hFF);
    wr(`ART_ADDR_CTRL, 8'h00);
    // 16-bit rollover: one tick from all ones must land on the reload value
    wr(`ART_ADDR_RLL, 8'h34);
    wr(`ART_ADDR_RLH, 8'h12);
    wr(`ART_ADDR_CNTL, 8'hFF);
    wr(`ART_ADDR_CNTH, 8'hFF);
    wr2(`ART_ADDR_CTRL, 8'h04, 8'h00);
    rd(`ART_ADDR_CNTL, 8'h34, 8'hFF);
    rd(`ART_ADDR_CNTH, 8'h12, 8'hFF);
    rd(`ART_ADDR_CTRL, 8'hC0, 8'hFF);
    chk(irq_out, 1'b1, "no irq on 16-bit overflow");
    wr(`ART_ADDR_CTRL, 8'h40);
    chk(irq_out, 1'b0, "low flag irq without enable");
    wr(`ART_ADDR_CTRL, 8'h60);
    chk(irq_out, 1'b1, "no low byte irq");
    rd(`ART_ADDR_CTRL, 8'h60, 8'hFF);
    irq_en = 1'b0;
    @(posedge clk_in);
    #1;
    chk(irq_out, 1'b0, "irq while disabled");
    irq_en = 1'b1;
    // split: low byte runs with run control clear, high byte holds
    wr(`ART_ADDR_CTRL, 8'h00);
    wr(`ART_ADDR_RLL, 8'hF0);
    wr(`ART_ADDR_RLH, 8'h80);
    wr(`ART_ADDR_CNTL, 8'hFE);
    wr(`ART_ADDR_CNTH, 8'hFF);
    wr(`ART_ADDR_CTRL, 8'h08);
    wait_flag(1'b0);
    repeat (40) @(posedge clk_in);
    #1;
    rd(`ART_ADDR_CNTH, 8'hFF, 8'hFF);
    rd(`ART_ADDR_CTRL, 8'h48, 8'hFF);
    rd(`ART_ADDR_CNTL, 8'hF0, 8'hF0);
    chk(irq_out, 1'b0, "split low irq without enable");
    wr(`ART_ADDR_CTRL, 8'h68);
    chk(irq_out, 1'b1, "split low irq missing");
    // clear the low flag and let the free-running low byte raise it again
    wr(`ART_ADDR_CTRL, 8'h28);
    wait_flag(1'b0);
    chk(irq_out, 1'b1, "no request from a low byte rollover");
    // slow the low byte so it stays quiet while the high byte rolls
    lsel = 1'b0;
    wr(`ART_ADDR_CTRL, 8'h0C);
    wait_flag(1'b1);
    wr(`ART_ADDR_CTRL, 8'h88);
    rd(`ART_ADDR_CTRL, 8'h88, 8'hBF);
    rd(`ART_ADDR_CNTH, 8'h80, 8'hF0);
    chk(irq_out, 1'b1, "split high irq missing");
    // system clock divided by 12, then external divided by 8
    wr(`ART_ADDR_CTRL, 8'h00);
    wr(`ART_ADDR_CNTL, 8'h00);
    wr(`ART_ADDR_CNTH, 8'h00);
    wr(`ART_ADDR_CTRL, 8'h04);
    repeat (118) @(posedge clk_in);
    #1;
    wr(`ART_ADDR_CTRL, 8'h00);
    rd(`ART_ADDR_CNTL, 8'h08, 8'hFC);
    // both bytes on system/12 in split mode, the high byte through its own select
    hsel = 1'b0;
    wr(`ART_ADDR_CNTL, 8'h00);
    wr(`ART_ADDR_CTRL, 8'h0C);
    repeat (118) @(posedge clk_in);
    #1;
    wr(`ART_ADDR_CTRL, 8'h00);
    rd(`ART_ADDR_CNTH, 8'h08, 8'hFC);
    rd(`ART_ADDR_CNTL, 8'h08, 8'hFC);
    hsel = 1'b1;
    wr(`ART_ADDR_CNTH, 8'h00);
    wr(`ART_ADDR_CNTL, 8'h00);
    wr(`ART_ADDR_CTRL, 8'h05);
    repeat (638) @(posedge clk_in);
    #1;
    wr(`ART_ADDR_CTRL, 8'h01);
    rd(`ART_ADDR_CNTL, 8'h08, 8'hFC);
    lsel = 1'b1;
    // capture: counter held still so the copied value is exact
    wr(`ART_ADDR_CTRL, 8'h00);
    wr(`ART_ADDR_CNTH, 8'h5A);
    wr(`ART_ADDR_CNTL, 8'h00);
    wr(`ART_ADDR_RLL, 8'h33);
    wr(`ART_ADDR_RLH, 8'h44);
    lfo_pulse();
    rd(`ART_ADDR_RLH, 8'h44, 8'hFF);
    rd(`ART_ADDR_CTRL, 8'h00, 8'hFF);
    wr(`ART_ADDR_CTRL, 8'h10);
    lfo_pulse();
    rd(`ART_ADDR_RLL, 8'h00, 8'hFF);
    rd(`ART_ADDR_RLH, 8'h5A, 8'hFF);
    rd(`ART_ADDR_CTRL, 8'h90, 8'hFF);
    chk(irq_out, 1'b1, "capture irq missing");
    wr(`ART_ADDR_CTRL, 8'h00);
    chk(hflag, 1'b0, "flag not cleared by write");
    repeat (4) @(posedge clk_in);
    stop_test();
  end
endmodule
